//--- core/flash_host_regs.svh
// Constants for the parallel flash host controller
// Functional notes
// - Main erase is six writes; sixth is 5555 hex with 30 hex.
// - Word program is four writes, then device times itself.
// - Host enables lockout with a six-write command sequence.
// - Host issues identification exit to return to normal reads.
// - Only low data byte carries command; upper byte ignored.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH
`define FH_UNLOCK_ADDR1 16'h5555
`define FH_UNLOCK_ADDR2 16'h2AAA
`define FH_UNLOCK_DATA1 8'hAA
`define FH_UNLOCK_DATA2 8'h55
`define FH_CMD_SETUP 8'h80
`define FH_CMD_CHIP_ERASE 8'h10
`define FH_CMD_MAIN_ERASE 8'h30
`define FH_CMD_LOCKOUT 8'h40
`define FH_CMD_PROGRAM 8'hA0
`define FH_CMD_ID_ENTRY 8'h90
`define FH_CMD_ID_EXIT 8'hF0
`define FH_LOCK_STATUS_ADDR 16'h0002
`define FH_BOOT_LAST_ADDR 16'h1FFF
`define FH_CLK_PERIOD_PS 5000
`define FH_STROBE_MIN_NS 15
`define FH_SETUP_MIN_NS 45
`define FH_STROBE_CYCLES ((`FH_STROBE_MIN_NS * 1000 + `FH_CLK_PERIOD_PS - 1) / `FH_CLK_PERIOD_PS)
`define FH_SETUP_CYCLES ((`FH_SETUP_MIN_NS * 1000 + `FH_CLK_PERIOD_PS - 1) / `FH_CLK_PERIOD_PS)
`endif

//--- core/flash_host_pkg.sv
// Types shared by the parallel flash host controller
package flash_host_pkg;
    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_PROGRAM = 3'b001,
        OP_CHIP_ERASE = 3'b010,
        OP_MAIN_ERASE = 3'b011,
        OP_LOCKOUT = 3'b100,
        OP_ID_ENTRY = 3'b101,
        OP_ID_EXIT = 3'b110,
        OP_ID_EXIT_SHORT = 3'b111
    } op_t;

    typedef struct packed {
        op_t op;
        logic [15:0] addr;
        logic [15:0] data;
    } req_t;

    typedef struct packed {
        logic chip_sel_n;
        logic out_en_n;
        logic write_n;
        logic [15:0] word_address_lines;
        logic [15:0] data_out;
        logic data_oe;
    } pins_t;

    typedef enum logic [2:0] {
        CYC_IDLE = 3'b000,
        CYC_SETUP = 3'b001,
        CYC_STROBE = 3'b010,
        CYC_HOLD = 3'b011,
        CYC_DONE = 3'b100
    } cyc_state_t;
endpackage

//--- core/flash_bus_cycle.sv
// One asynchronous bus cycle, read or write, on the flash pins
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_bus_cycle (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic is_write,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] data_in_sync,
    output flash_host_pkg::pins_t pins,
    output logic [15:0] rdata,
    output logic done
);
    localparam logic [3:0] SETUP_CNT = 4'(`FH_SETUP_CYCLES);
    localparam logic [3:0] STROBE_CNT = 4'(`FH_STROBE_CYCLES);
    // Read data needs two sync stages plus access time before sampling
    localparam logic [3:0] READ_CNT = 4'(`FH_SETUP_CYCLES + 2);

    flash_host_pkg::cyc_state_t state_reg, state_next;
    flash_host_pkg::pins_t pins_reg, pins_next;
    logic [3:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic [15:0] rdata_reg, rdata_next;
    logic done_reg, done_next;

    always_comb begin
        state_next = state_reg;
        pins_next = pins_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        rdata_next = rdata_reg;
        done_next = 1'b0;
        unique case (state_reg)
            flash_host_pkg::CYC_IDLE: begin
                if (start) begin
                    // Address and data settle before any strobe falls
                    pins_next.word_address_lines = addr;
                    pins_next.data_out = wdata;
                    pins_next.data_oe = is_write;
                    pins_next.chip_sel_n = 1'b0;
                    wr_next = is_write;
                    cnt_next = 4'h0;
                    state_next = flash_host_pkg::CYC_SETUP;
                end
            end
            flash_host_pkg::CYC_SETUP: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == 4'h0) begin
                    // Write strobe falls last, so address latches on it
                    pins_next.write_n = ~wr_reg;
                    pins_next.out_en_n = wr_reg;
                    cnt_next = 4'h0;
                    state_next = flash_host_pkg::CYC_STROBE;
                end
            end
            flash_host_pkg::CYC_STROBE: begin
                cnt_next = cnt_reg + 4'h1;
                // Strobe held well past the noise filter width
                if (wr_reg ? (cnt_reg >= STROBE_CNT + SETUP_CNT) : (cnt_reg >= READ_CNT)) begin
                    if (!wr_reg) begin
                        rdata_next = data_in_sync;
                    end
                    // Write rises first, data latched there
                    pins_next.write_n = 1'b1;
                    pins_next.out_en_n = 1'b1;
                    state_next = flash_host_pkg::CYC_HOLD;
                end
            end
            flash_host_pkg::CYC_HOLD: begin
                pins_next.chip_sel_n = 1'b1;
                pins_next.data_oe = 1'b0;
                state_next = flash_host_pkg::CYC_DONE;
            end
            flash_host_pkg::CYC_DONE: begin
                done_next = 1'b1;
                state_next = flash_host_pkg::CYC_IDLE;
            end
            default: state_next = flash_host_pkg::CYC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= flash_host_pkg::CYC_IDLE;
            pins_reg <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, write_n: 1'b1,
                word_address_lines: 16'h0000, data_out: 16'h0000, data_oe: 1'b0};
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
        end
    end

    assign pins = pins_reg;
    assign rdata = rdata_reg;
    assign done = done_reg;

    chk_no_write_with_oe: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(pins_reg.write_n == 1'b0 && pins_reg.out_en_n == 1'b0))
        else $error("write strobe low while output enable low");
    chk_write_needs_cs: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !pins_reg.write_n |-> !pins_reg.chip_sel_n)
        else $error("write strobe low without chip select");
    chk_strobe_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(pins_reg.write_n) |-> !pins_reg.write_n [*4])
        else $error("write strobe pulse too narrow");
    chk_data_stable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !pins_reg.write_n |-> $stable(pins_reg.data_out) && $stable(pins_reg.word_address_lines))
        else $error("address or data moved during write strobe");
endmodule

//--- core/flash_host_ctrl.sv
// Host controller that issues command sequences to a 64K x 16 parallel flash
`timescale 1ns/1ps
`include "flash_host_regs.svh"
module flash_host_ctrl #(
    parameter int POLL_LIMIT = 65535
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic req_valid,
    input flash_host_pkg::req_t req,
    output logic req_ready,
    output logic resp_valid,
    output logic [15:0] resp_data,
    output logic resp_timeout,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_n,
    output logic [15:0] word_address_lines,
    output logic [15:0] bidir_data_lines_out,
    output logic bidir_data_lines_oe,
    input wire logic [15:0] bidir_data_lines_in
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ISSUE = 3'b001,
        ST_WAIT = 3'b010,
        ST_POLL = 3'b011,
        ST_POLL_WAIT = 3'b100,
        ST_REPLY = 3'b101
    } state_t;

    // Step count of each command sequence
    function automatic logic [2:0] seq_len(input flash_host_pkg::op_t op);
        unique case (op)
            flash_host_pkg::OP_READ: seq_len = 3'd1;
            flash_host_pkg::OP_PROGRAM: seq_len = 3'd4;
            flash_host_pkg::OP_ID_ENTRY, flash_host_pkg::OP_ID_EXIT: seq_len = 3'd3;
            flash_host_pkg::OP_ID_EXIT_SHORT: seq_len = 3'd1;
            default: seq_len = 3'd6;
        endcase
    endfunction

    // Final command byte for a six-write sequence
    function automatic logic [7:0] last_cmd(input flash_host_pkg::op_t op);
        unique case (op)
            flash_host_pkg::OP_CHIP_ERASE: last_cmd = `FH_CMD_CHIP_ERASE;
            flash_host_pkg::OP_MAIN_ERASE: last_cmd = `FH_CMD_MAIN_ERASE;
            default: last_cmd = `FH_CMD_LOCKOUT;
        endcase
    endfunction

    logic [2:0] step_reg, step_next;
    state_t state_reg, state_next;
    flash_host_pkg::req_t cur_reg, cur_next;
    logic [15:0] last_rd_reg, last_rd_next;
    logic [15:0] resp_reg, resp_next;
    logic resp_valid_reg, resp_valid_next;
    logic timeout_reg, timeout_next;
    logic [15:0] poll_reg, poll_next;
    logic first_poll_reg, first_poll_next;
    logic ready_reg;
    logic [15:0] din_meta_reg, din_sync_reg;

    logic cyc_start;
    logic cyc_write;
    logic [15:0] cyc_addr;
    logic [15:0] cyc_data;
    flash_host_pkg::pins_t pins;
    logic [15:0] cyc_rdata;
    logic cyc_done;

    // Pin data crosses from the asynchronous bus
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            din_meta_reg <= 16'h0000;
            din_sync_reg <= 16'h0000;
        end else begin
            din_meta_reg <= bidir_data_lines_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    flash_bus_cycle u_cycle (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_data),
        .data_in_sync(din_sync_reg),
        .pins(pins),
        .rdata(cyc_rdata),
        .done(cyc_done)
    );

    // Address and data of the current step
    always_comb begin
        cyc_write = 1'b1;
        cyc_addr = `FH_UNLOCK_ADDR1;
        cyc_data = {8'h00, `FH_UNLOCK_DATA1};
        if (cur_reg.op == flash_host_pkg::OP_READ) begin
            cyc_write = 1'b0;
            cyc_addr = cur_reg.addr;
        end else if (cur_reg.op == flash_host_pkg::OP_ID_EXIT_SHORT) begin
            cyc_data = {8'h00, `FH_CMD_ID_EXIT};
        end else begin
            unique case (step_reg)
                3'd1, 3'd4: begin
                    cyc_addr = `FH_UNLOCK_ADDR2;
                    cyc_data = {8'h00, `FH_UNLOCK_DATA2};
                end
                3'd2: begin
                    unique case (cur_reg.op)
                        flash_host_pkg::OP_PROGRAM: cyc_data = {8'h00, `FH_CMD_PROGRAM};
                        flash_host_pkg::OP_ID_ENTRY: cyc_data = {8'h00, `FH_CMD_ID_ENTRY};
                        flash_host_pkg::OP_ID_EXIT: cyc_data = {8'h00, `FH_CMD_ID_EXIT};
                        default: cyc_data = {8'h00, `FH_CMD_SETUP};
                    endcase
                end
                3'd3: begin
                    if (cur_reg.op == flash_host_pkg::OP_PROGRAM) begin
                        cyc_addr = cur_reg.addr;
                        cyc_data = cur_reg.data;
                    end
                end
                3'd5: cyc_data = {8'h00, last_cmd(cur_reg.op)};
                default: ;
            endcase
        end
        if (state_reg == ST_POLL) begin
            cyc_write = 1'b0;
            cyc_addr = cur_reg.addr;
        end
    end

    assign cyc_start = (state_reg == ST_ISSUE) || (state_reg == ST_POLL);

    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        cur_next = cur_reg;
        last_rd_next = last_rd_reg;
        resp_next = resp_reg;
        resp_valid_next = 1'b0;
        timeout_next = timeout_reg;
        poll_next = poll_reg;
        first_poll_next = first_poll_reg;
        unique case (state_reg)
            ST_IDLE: begin
                // Ready is low on the first edge after reset, so nothing is taken there
                if (req_valid && ready_reg) begin
                    cur_next = req;
                    step_next = 3'd0;
                    timeout_next = 1'b0;
                    state_next = ST_ISSUE;
                end
            end
            ST_ISSUE: state_next = ST_WAIT;
            ST_WAIT: begin
                if (cyc_done) begin
                    if (step_reg + 3'd1 < seq_len(cur_reg.op)) begin
                        step_next = step_reg + 3'd1;
                        state_next = ST_ISSUE;
                    end else if (cur_reg.op == flash_host_pkg::OP_READ) begin
                        resp_next = cyc_rdata;
                        state_next = ST_REPLY;
                    end else if (cur_reg.op == flash_host_pkg::OP_PROGRAM
                        || cur_reg.op == flash_host_pkg::OP_CHIP_ERASE
                        || cur_reg.op == flash_host_pkg::OP_MAIN_ERASE) begin
                        // Device self-times; wait by polling
                        poll_next = 16'h0000;
                        first_poll_next = 1'b1;
                        state_next = ST_POLL;
                    end else begin
                        resp_next = 16'h0000;
                        state_next = ST_REPLY;
                    end
                end
            end
            ST_POLL: state_next = ST_POLL_WAIT;
            ST_POLL_WAIT: begin
                if (cyc_done) begin
                    last_rd_next = cyc_rdata;
                    first_poll_next = 1'b0;
                    poll_next = poll_reg + 16'h0001;
                    // Two reads with equal bit 6 mean the alternating line stopped
                    if (!first_poll_reg && cyc_rdata[6] == last_rd_reg[6]) begin
                        resp_next = cyc_rdata;
                        state_next = ST_REPLY;
                    end else if (poll_reg == 16'(POLL_LIMIT)) begin
                        timeout_next = 1'b1;
                        resp_next = cyc_rdata;
                        state_next = ST_REPLY;
                    end else begin
                        state_next = ST_POLL;
                    end
                end
            end
            ST_REPLY: begin
                resp_valid_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            step_reg <= 3'd0;
            cur_reg <= '0;
            last_rd_reg <= 16'h0000;
            resp_reg <= 16'h0000;
            resp_valid_reg <= 1'b0;
            timeout_reg <= 1'b0;
            poll_reg <= 16'h0000;
            first_poll_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            cur_reg <= cur_next;
            last_rd_reg <= last_rd_next;
            resp_reg <= resp_next;
            resp_valid_reg <= resp_valid_next;
            timeout_reg <= timeout_next;
            poll_reg <= poll_next;
            first_poll_reg <= first_poll_next;
        end
    end

    // Ready is a flop loaded from the next state, so it matches the current state except in the first cycle after reset, when it is low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (state_next == ST_IDLE);
        end
    end

    assign req_ready = ready_reg;
    assign resp_valid = resp_valid_reg;
    assign resp_data = resp_reg;
    assign resp_timeout = timeout_reg;
    assign chip_sel_n = pins.chip_sel_n;
    assign out_en_n = pins.out_en_n;
    assign write_n = pins.write_n;
    assign word_address_lines = pins.word_address_lines;
    assign bidir_data_lines_out = pins.data_out;
    assign bidir_data_lines_oe = pins.data_oe;

    chk_no_drive_on_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !out_en_n |-> !bidir_data_lines_oe)
        else $error("host drives data while flash output enabled");
    chk_sixth_write_cmd: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_ISSUE && step_reg == 3'd5
            && cur_reg.op == flash_host_pkg::OP_MAIN_ERASE)
        |-> cyc_addr == 16'h5555 && cyc_data[7:0] == 8'h30)
        else $error("sixth main erase write wrong");
    chk_program_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_WAIT && cyc_done && cur_reg.op == flash_host_pkg::OP_PROGRAM)
        |-> (step_reg == 3'd3) == (state_next == ST_POLL))
        else $error("program sequence length not four");
    chk_poll_after_erase: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == ST_WAIT && cyc_done && step_reg == 3'd5
            && cur_reg.op != flash_host_pkg::OP_LOCKOUT)
        |=> state_reg == ST_POLL)
        else $error("erase not followed by polling");
endmodule

//--- dv/flash_word_model.sv
// Behavioural word-wide flash device standing on the host controller's pins
`timescale 1ns/1ps
module flash_word_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00A5, // Arbitrary identity value
    parameter logic [15:0] PART_CODE = 16'h003C // Arbitrary identity value
) (
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_n,
    input wire logic [15:0] word_address_lines,
    input wire logic [15:0] data_in,
    input wire logic [7:0] busy_len,
    output logic [15:0] data_line,
    output logic drive_en
);
    logic [15:0] mem [int];
    logic [15:0] a_lat = 16'h0000, rd_val = 16'h0000, prog_last = 16'h0000, last_val = 16'h0000;
    logic locked = 0, id_mode = 0, tog = 0, wr_on = 0, rd_busy = 0;
    int st = 0, busy = 0;
    realtime t_fall = 0;
    function automatic logic [15:0] rd(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    // Commands arriving while busy are dropped, as the real part ignores them
    task automatic cmd(input logic [15:0] a, input logic [15:0] d);
        if (busy > 0) return;
        if (st == 3) begin
            if (!(locked && a <= 16'h1FFF)) mem[a] = rd(a) & d;
            prog_last = d;
            busy = busy_len;
            st = 0;
        end else if (d[7:0] == 8'hF0 && st != 2) begin
            id_mode = 0;
            st = 0;
        end else if ((st % 2 == 0) ? a != 16'h5555 : a != 16'h2AAA) begin
            st = 0;
        end else if (st == 2) begin
            st = d[7:0] == 8'hA0 ? 3 : d[7:0] == 8'h80 ? 4 : 0;
            if (d[7:0] == 8'h90) id_mode = 1;
            if (d[7:0] == 8'hF0) id_mode = 0;
        end else if (st == 6) begin
            st = 0;
            if (d[7:0] == 8'h40) locked = 1;
            if (d[7:0] == 8'h10 && !locked) mem.delete();
            if (d[7:0] == 8'h10 || d[7:0] == 8'h30) begin
                for (int k = 16'h2000; k < 65536; k++) mem.delete(k);
                prog_last = 16'hFFFF;
                busy = busy_len;
            end
        end else begin
            st = (d[7:0] == ((st % 2) ? 8'h55 : 8'hAA)) ? st + 1 : 0;
        end
    endtask
    always @(negedge write_n or negedge chip_sel_n) begin
        if (!write_n && !chip_sel_n && out_en_n) begin
            a_lat = word_address_lines;
            t_fall = $realtime;
            wr_on = 1;
        end
    end
    always @(posedge write_n or posedge chip_sel_n) begin
        if (wr_on && out_en_n && $realtime - t_fall >= 15.0) cmd(a_lat, data_in);
        wr_on = 0;
    end
    always @(negedge out_en_n) begin
        if (!chip_sel_n && write_n) begin
            rd_busy = busy > 0;
            if (rd_busy) busy = busy - 1;
            if (rd_busy) tog = ~tog;
            if (rd_busy) rd_val = {prog_last[15:8], ~prog_last[7], tog, prog_last[5:0]};
            else if (id_mode && word_address_lines == 16'h0002) rd_val = {15'h0000, locked};
            else if (id_mode && word_address_lines < 16'h0002)
                rd_val = word_address_lines[0] ? PART_CODE : MAKER_CODE;
            else rd_val = rd(word_address_lines);
        end
    end
    assign drive_en = !chip_sel_n && !out_en_n && write_n;
    always @(rd_val or drive_en) if (drive_en) last_val = rd_val;
    // Released lines show the inverse so stale data is never mistaken for a read
    assign data_line = drive_en ? rd_val : ~last_val;
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the flash host controller against a device model
`timescale 1ns/1ps
module tb_top;
    localparam logic [15:0] MAKER = 16'h00A5;
    localparam logic [15:0] PART = 16'h003C;
    logic clk_sys = 0, reset_n = 0, req_valid = 0, e_locked = 0;
    flash_host_pkg::req_t req = '0;
    logic req_ready, resp_valid, resp_timeout, chip_sel_n, out_en_n, write_n, bus_oe, mdl_oe;
    logic [15:0] resp_data, word_address_lines, bus_out, mdl_line, bus_in, rdata;
    logic [7:0] busy_len = 8'h03;
    logic [15:0] exp_mem [int];
    logic [15:0] addrs [8] = '{16'h0000, 16'h1FFF, 16'h2000, 16'hFFFF, 0, 0, 0, 0};
    int n_errors = 0, tests_run = 0, seed = 85;
    assign bus_in = bus_oe ? bus_out : mdl_line;
    flash_host_ctrl #(.POLL_LIMIT(8)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_timeout(resp_timeout), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_n(write_n), .word_address_lines(word_address_lines),
        .bidir_data_lines_out(bus_out), .bidir_data_lines_oe(bus_oe),
        .bidir_data_lines_in(bus_in));
    flash_word_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) model (.chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_n(write_n), .word_address_lines(word_address_lines),
        .data_in(bus_out), .busy_len(busy_len), .data_line(mdl_line), .drive_en(mdl_oe));
    initial forever #2.5 clk_sys = ~clk_sys;
    // Host and device must never drive the data lines together
    always @(negedge clk_sys) begin
        if (reset_n && bus_oe && mdl_oe) begin
            n_errors++;
            $display("ERROR t=%0t bus contention exp=%h got=%h", $time, 1'b0, 1'b1);
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (e !== g) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [15:0] exp_rd(input logic [15:0] a);
        return exp_mem.exists(a) ? exp_mem[a] : 16'hFFFF;
    endfunction
    // Waits are bounded so a stuck handshake shows up as a mismatch
    task automatic rq(input flash_host_pkg::op_t op, input logic [15:0] ad, input logic [15:0] dt);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys);
            n++;
        end
        req = '{op: op, addr: ad, data: dt};
        req_valid = 1;
        @(negedge clk_sys);
        req_valid = 0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(16'h0001, {15'h0000, resp_valid});
        rdata = resp_data;
    endtask
    task automatic rd(input logic [15:0] ad);
        rq(flash_host_pkg::OP_READ, ad, 16'h0000);
    endtask
    task automatic prog(input logic [15:0] ad, input logic [15:0] dt);
        rq(flash_host_pkg::OP_PROGRAM, ad, dt);
        if (!(e_locked && ad <= 16'h1FFF)) exp_mem[ad] = exp_rd(ad) & dt;
        chk(exp_rd(ad), rdata);
        chk(16'h0000, {15'h0000, resp_timeout});
        rd(ad);
        chk(exp_rd(ad), rdata);
    endtask
    task automatic erase(input flash_host_pkg::op_t op, input string s);
        rq(op, 16'h2000, 16'h0000);
        if (op == flash_host_pkg::OP_CHIP_ERASE && !e_locked) exp_mem.delete();
        for (int k = 16'h2000; k < 65536; k++) exp_mem.delete(k);
        foreach (addrs[i]) begin
            rd(addrs[i]);
            chk(exp_rd(addrs[i]), rdata);
        end
        $display("test %s done", s);
    endtask
    task automatic id_check(input flash_host_pkg::op_t ex);
        rq(flash_host_pkg::OP_ID_ENTRY, 16'h5555, 16'h0000);
        rd(16'h0000);
        chk(MAKER, rdata);
        rd(16'h0001);
        chk(PART, rdata);
        rd(16'h0002);
        chk({15'h0000, e_locked}, rdata);
        rq(ex, 16'h5555, 16'h0000);
        rd(16'h0002);
        chk(exp_rd(16'h0002), rdata);
        $display("test id_mode done");
    endtask
    initial begin
        #400000;
        n_errors++;
        $display("ERROR t=%0t watchdog exp=%h got=%h", $time, 1'b1, 1'b0);
        wrap_up();
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        reset_n = 1;
        for (int i = 4; i < 8; i++) addrs[i] = 16'($random(seed));
        foreach (addrs[i]) begin
            rd(addrs[i]);
            chk(16'hFFFF, rdata);
        end
        $display("test read_erased done");
        for (int j = 0; j < 2; j++) begin
            foreach (addrs[i]) prog(addrs[i], 16'($random(seed)));
        end
        $display("test program done");
        erase(flash_host_pkg::OP_CHIP_ERASE, "chip_erase_open");
        foreach (addrs[i]) prog(addrs[i], 16'($random(seed)));
        $display("test reprogram done");
        erase(flash_host_pkg::OP_MAIN_ERASE, "main_erase");
        id_check(flash_host_pkg::OP_ID_EXIT);
        rq(flash_host_pkg::OP_LOCKOUT, 16'h5555, 16'h0000);
        e_locked = 1;
        id_check(flash_host_pkg::OP_ID_EXIT_SHORT);
        prog(addrs[1], 16'h0000);
        prog(addrs[2], 16'($random(seed)));
        $display("test lockout done");
        erase(flash_host_pkg::OP_CHIP_ERASE, "chip_erase_locked");
        busy_len = 8'd20;
        rq(flash_host_pkg::OP_PROGRAM, 16'h4000, 16'($random(seed)));
        chk(16'h0001, {15'h0000, resp_timeout});
        $display("test poll_timeout done");
        wrap_up();
    end
endmodule
